// ===== hdl/pda_alarm.sv
/*
 * Process/deviation alarm: compares a monitored value with absolute
 * limits or with a window around a center reference and drives one
 * digital alarm output.
 * Assumes all inputs come from logic on core_clk and that limits stay
 * within the documented signed range.
 */
`timescale 1ns/1ps
// Functional notes
// - Type off holds the alarm output off whatever the value.
// - Process mode: high above high limit, low below low limit.
// - Sides picks both, high only or low only; other side never alarms.
// - Process limits are signed absolutes from -99,999 to 99,999.
// - Process alarms clear only once back past the limit by hysteresis.
// - Deviation high: value above center plus high offset.
// - Deviation low: value below center plus low offset.
// - Deviation offsets are signed, -99,999 to 99,999, either side of center.
// - Deviation trip points follow the live center every cycle.
// - Deviation hysteresis is measured from each trip point.
// - Condition must persist the delay, 0 to 9,999 s; early return cancels.
// - Latching: alarm holds until condition ends and a clear request comes.
// - Non-latching: alarm drops once condition and hysteresis allow.
// - Silencing enabled: mute request turns output inactive unless an input error stands, state stays.
// - Silenced output waits for a clear and a fresh alarm.
// - Silencing disabled: mute requests ignored.
// - Blocking suppresses alarms until the value first reads normal.
// - Startup blocking arms at reset; both also re-arms deviation blocking on setting changes.
// - Set-point blocking re-arms deviation blocking on center or limit change.
// - Polarity picks close on alarm or open on alarm output level.
// - Display option raises an attention flag while an alarm is active.
// - Clear parameter resets the alarm state once the cause is gone.
// - Silence parameter turns the output inactive after an alarm.
// - Disable input acts like type off, but deviation set-point blocking still re-arms.
// - Input error sets alarm state and drives the output active.
// - The block's own error status always reads none.
module pda_alarm #(
   parameter int unsigned TICK_CYCLES = pda_pkg::TICK_CYCLES
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic signed [pda_pkg::VAL_W-1:0] monitored_value,
   input wire logic [pda_pkg::ERR_W-1:0] monitored_error,
   input wire logic signed [pda_pkg::VAL_W-1:0] center_reference,
   input wire logic mute_request,
   input wire logic acknowledge_request,
   input wire logic disable_request,
   input wire pda_pkg::pda_type_e cfg_type,
   input wire pda_pkg::pda_side_e cfg_sides,
   input wire logic signed [pda_pkg::VAL_W-1:0] cfg_low_limit,
   input wire logic signed [pda_pkg::VAL_W-1:0] cfg_high_limit,
   input wire logic [pda_pkg::HYST_W-1:0] cfg_hysteresis,
   input wire logic [pda_pkg::DELAY_W-1:0] cfg_delay_s,
   input wire logic cfg_latching,
   input wire logic cfg_silence_en,
   input wire pda_pkg::pda_block_e cfg_blocking,
   input wire logic cfg_close_on_alarm,
   input wire logic cfg_display_en,
   input wire logic cfg_clear_param,
   input wire logic cfg_silence_param,
   output logic alarm_out,
   output logic display_attention,
   output logic alarm_state,
   output logic alarm_high,
   output logic alarm_low,
   output logic alarm_blocked,
   output logic [pda_pkg::ERR_W-1:0] out_error_status
);

   typedef logic signed [pda_pkg::CALC_W-1:0] pda_calc_t;

   // ==========================================================
   // Enable and mode decode
   wire type_on = (cfg_type != pda_pkg::PDA_TYPE_OFF);
   wire active_en = type_on && !disable_request;
   wire is_dev = (cfg_type == pda_pkg::PDA_TYPE_DEVIATION);
   wire watch_hi = (cfg_sides != pda_pkg::PDA_SIDE_LOW);
   wire watch_lo = (cfg_sides != pda_pkg::PDA_SIDE_HIGH);

   // ==========================================================
   // Widened operands
   // Two spare bits keep center plus offset, minus hysteresis, from wrapping
   wire pda_calc_t val_w = pda_calc_t'(monitored_value);
   wire pda_calc_t ctr_w = pda_calc_t'(center_reference);
   wire pda_calc_t lo_w = pda_calc_t'(cfg_low_limit);
   wire pda_calc_t hi_w = pda_calc_t'(cfg_high_limit);
   wire pda_calc_t hyst_w = pda_calc_t'({1'b0, cfg_hysteresis});

   // ==========================================================
   // Trip points
   // Recomputed combinationally so a moving center moves the window at once
   wire pda_calc_t base_w = is_dev ? ctr_w : '0;
   wire pda_calc_t hi_trip = pda_calc_t'(base_w + hi_w);
   wire pda_calc_t lo_trip = pda_calc_t'(base_w + lo_w);
   wire pda_calc_t hi_rel = pda_calc_t'(hi_trip - hyst_w);
   wire pda_calc_t lo_rel = pda_calc_t'(lo_trip + hyst_w);

   // ==========================================================
   // Raw conditions, side masked
   wire hi_cond = watch_hi && (val_w > hi_trip);
   wire lo_cond = watch_lo && (val_w < lo_trip);
   wire in_normal = !hi_cond && !lo_cond;

   // A side is back to normal only past its trip point by the hysteresis
   wire hi_back = !watch_hi || (val_w <= hi_rel);
   wire lo_back = !watch_lo || (val_w >= lo_rel);

   // ==========================================================
   // Input error
   wire input_err = active_en && (monitored_error != pda_pkg::ERR_NONE);

   // ==========================================================
   // Blocking
   logic block_q;
   logic block_d;
   logic started_q;
   logic signed [pda_pkg::VAL_W-1:0] ctr_prev_q;
   logic signed [pda_pkg::VAL_W-1:0] lo_prev_q;
   logic signed [pda_pkg::VAL_W-1:0] hi_prev_q;

   wire blk_startup = (cfg_blocking == pda_pkg::PDA_BLK_STARTUP) ||
                      (cfg_blocking == pda_pkg::PDA_BLK_BOTH);
   wire blk_setpt = (cfg_blocking == pda_pkg::PDA_BLK_SETPOINT) ||
                    (cfg_blocking == pda_pkg::PDA_BLK_BOTH);
   wire setting_chg = (center_reference != ctr_prev_q) ||
                      (cfg_low_limit != lo_prev_q) ||
                      (cfg_high_limit != hi_prev_q);
   // Only deviation alarms re-arm on a setting change; off never re-arms
   wire rearm = started_q && blk_setpt && is_dev && setting_chg;

   // Re-arming wins over release when both land in one cycle
   always_comb begin
      if (!started_q) begin
         block_d = blk_startup;
      end else if (rearm) begin
         block_d = 1'b1;
      end else if (in_normal || cfg_blocking == pda_pkg::PDA_BLK_OFF) begin
         block_d = 1'b0;
      end else begin
         block_d = block_q;
      end
   end

   // Strap-like arming is caught on the first edge after release
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         block_q <= pda_pkg::BLOCK_RST;
         started_q <= pda_pkg::STARTED_RST;
      end else begin
         block_q <= block_d;
         started_q <= 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ctr_prev_q <= '0;
         lo_prev_q <= '0;
         hi_prev_q <= '0;
      end else begin
         ctr_prev_q <= center_reference;
         lo_prev_q <= cfg_low_limit;
         hi_prev_q <= cfg_high_limit;
      end
   end

   // ==========================================================
   // Delay qualification
   pda_qual_if qif ();

   // Blocked or disabled conditions never start the delay count
   // A setting change masks its own cycle, before block_q has caught up
   wire eval_en = active_en && !block_q && !rearm;
   assign qif.cond = {lo_cond, hi_cond} & {2{eval_en}};
   assign qif.delay_s = cfg_delay_s;

   pda_delay_qual #(
      .TICK_CYCLES(TICK_CYCLES)
   ) u_qual (
      .core_clk(core_clk),
      .rstn(rstn),
      .qif(qif)
   );

   // ==========================================================
   // Alarm state per side
   logic [1:0] alarm_q;
   logic [1:0] alarm_d;

   wire clear_req = acknowledge_request || cfg_clear_param;
   wire release_ok = !cfg_latching || clear_req;
   wire [1:0] back = {lo_back, hi_back};
   wire [1:0] drop = back & ~qif.met & {2{release_ok}};

   // A qualified condition wins over a clear in the same cycle
   assign alarm_d = active_en ? (qif.met | (alarm_q & ~drop)) : '0;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         alarm_q <= pda_pkg::ALARM_RST;
      end else begin
         alarm_q <= alarm_d;
      end
   end

   wire any_alarm_d = (|alarm_d) || input_err;

   // ==========================================================
   // Silencing
   logic mute_q;
   logic mute_d;

   wire mute_req = mute_request || cfg_silence_param;
   wire mute_take = cfg_silence_en && mute_req;

   // Mute is dropped only with the alarm state, so a new alarm shows again
   always_comb begin
      if (!any_alarm_d) begin
         mute_d = 1'b0;
      end else if (mute_take) begin
         mute_d = 1'b1;
      end else begin
         mute_d = mute_q;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         mute_q <= pda_pkg::MUTE_RST;
      end else begin
         mute_q <= mute_d;
      end
   end

   // ==========================================================
   // Output level
   // An input error overrides muting so a broken sensor is always seen
   wire out_active = input_err || (any_alarm_d && !mute_d);
   wire out_level = cfg_close_on_alarm ? out_active : !out_active;
   wire out_d = active_en && out_level;
   wire disp_d = cfg_display_en && any_alarm_d;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         alarm_out <= pda_pkg::OUT_RST;
         display_attention <= 1'b0;
         alarm_state <= 1'b0;
         alarm_high <= 1'b0;
         alarm_low <= 1'b0;
         alarm_blocked <= pda_pkg::BLOCK_RST;
         out_error_status <= pda_pkg::ERR_NONE;
      end else begin
         alarm_out <= out_d;
         display_attention <= disp_d;
         alarm_state <= any_alarm_d;
         alarm_high <= alarm_d[pda_pkg::SIDE_HI];
         alarm_low <= alarm_d[pda_pkg::SIDE_LO];
         alarm_blocked <= block_d;
         out_error_status <= pda_pkg::ERR_NONE;
      end
   end

endmodule

// ===== hdl/pda_pkg.sv
/*
 * Constants and types shared by the process/deviation alarm block.
 * Assumes one 25 MHz clock and signed values held as plain integers.
 */
package pda_pkg;

   // ==========================================================
   // Clock and timing
   localparam int unsigned CLK_HZ = 25_000_000;
   localparam int unsigned TICK_PERIOD_S = 1;
   localparam int unsigned TICK_CYCLES = CLK_HZ * TICK_PERIOD_S;
   localparam int unsigned TICK_W = 25;

   // ==========================================================
   // Value widths and ranges
   localparam int unsigned VAL_W = 18;
   localparam int unsigned CALC_W = 20;
   localparam int unsigned HYST_W = 14;
   localparam int unsigned DELAY_W = 14;
   localparam int VAL_MIN = -99_999;
   localparam int VAL_MAX = 99_999;
   localparam int unsigned HYST_MIN = 1;
   localparam int unsigned HYST_MAX = 9_999;
   localparam logic [DELAY_W-1:0] DELAY_MAX_S = 14'h270f;

   // ==========================================================
   // Error status of analog signals
   localparam int unsigned ERR_W = 4;
   localparam logic [ERR_W-1:0] ERR_NONE = 4'h0;

   // ==========================================================
   // Reset values
   localparam logic BLOCK_RST = 1'b1;
   localparam logic STARTED_RST = 1'b0;
   localparam logic [1:0] ALARM_RST = 2'h0;
   localparam logic MUTE_RST = 1'b0;
   localparam logic OUT_RST = 1'b0;

   // ==========================================================
   // Configuration encodings
   typedef enum logic [1:0] {
      PDA_TYPE_OFF = 2'h0,
      PDA_TYPE_PROCESS = 2'h1,
      PDA_TYPE_DEVIATION = 2'h2
   } pda_type_e;

   typedef enum logic [1:0] {
      PDA_SIDE_BOTH = 2'h0,
      PDA_SIDE_HIGH = 2'h1,
      PDA_SIDE_LOW = 2'h2
   } pda_side_e;

   typedef enum logic [1:0] {
      PDA_BLK_OFF = 2'h0,
      PDA_BLK_STARTUP = 2'h1,
      PDA_BLK_SETPOINT = 2'h2,
      PDA_BLK_BOTH = 2'h3
   } pda_block_e;

   // Side index in two-bit condition vectors
   localparam int unsigned SIDE_HI = 0;
   localparam int unsigned SIDE_LO = 1;

endpackage

// ===== hdl/pda_qual_if.sv
/*
 * Carrier between the alarm core and its delay qualifier.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface pda_qual_if;
   logic [1:0] cond;
   logic [pda_pkg::DELAY_W-1:0] delay_s;
   logic [1:0] met;

   modport core (output cond, output delay_s, input met);
   modport qual (input cond, input delay_s, output met);
endinterface

// ===== hdl/pda_delay_qual.sv
/*
 * Per-side delay qualifier: a condition must hold for delay_s whole
 * seconds before it is reported as met.
 * Assumes cond comes from logic on core_clk.
 */
`timescale 1ns/1ps
module pda_delay_qual #(
   parameter int unsigned TICK_CYCLES = pda_pkg::TICK_CYCLES
) (
   input wire logic core_clk,
   input wire logic rstn,
   pda_qual_if.qual qif
);

   localparam logic [pda_pkg::TICK_W-1:0] TICK_LAST =
      pda_pkg::TICK_W'(TICK_CYCLES - 1);

   // ==========================================================
   // One second divider and counter per side
   // Divider restarts with the condition, so no phase error shortens the delay
   for (genvar i = 0; i < 2; i++) begin : g_side
      logic [pda_pkg::TICK_W-1:0] div_q;
      logic [pda_pkg::DELAY_W-1:0] sec_q;
      wire tick = (div_q == TICK_LAST);
      wire sat = (sec_q == pda_pkg::DELAY_MAX_S);

      always_ff @(posedge core_clk or negedge rstn) begin
         if (!rstn) begin
            div_q <= '0;
            sec_q <= '0;
         end else if (!qif.cond[i]) begin
            div_q <= '0;
            sec_q <= '0;
         end else begin
            div_q <= tick ? '0 : div_q + 1'b1;
            if (tick && !sat) begin
               sec_q <= sec_q + 1'b1;
            end
         end
      end

      assign qif.met[i] = qif.cond[i] && (sec_q >= qif.delay_s);
   end

endmodule

// ===== tb/pda_alarm_assertions.sv
/*
 * Concurrent checks on the alarm block's top ports.
 * Assumes one clock core_clk and the asynchronous active low rstn.
 */
`timescale 1ns/1ps
module pda_alarm_assertions (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic signed [pda_pkg::VAL_W-1:0] monitored_value,
   input wire logic [pda_pkg::ERR_W-1:0] monitored_error,
   input wire logic signed [pda_pkg::VAL_W-1:0] center_reference,
   input wire logic mute_request,
   input wire logic disable_request,
   input wire pda_pkg::pda_type_e cfg_type,
   input wire pda_pkg::pda_side_e cfg_sides,
   input wire logic signed [pda_pkg::VAL_W-1:0] cfg_low_limit,
   input wire logic signed [pda_pkg::VAL_W-1:0] cfg_high_limit,
   input wire logic [pda_pkg::DELAY_W-1:0] cfg_delay_s,
   input wire logic cfg_silence_en,
   input wire logic cfg_close_on_alarm,
   input wire logic cfg_display_en,
   input wire logic alarm_out,
   input wire logic display_attention,
   input wire logic alarm_state,
   input wire logic alarm_high,
   input wire logic alarm_low,
   input wire logic alarm_blocked,
   input wire logic [pda_pkg::ERR_W-1:0] out_error_status
);
   // ==========================================================
   // Properties
   property p_off;
      @(posedge core_clk) disable iff (!rstn)
      (disable_request || cfg_type == pda_pkg::PDA_TYPE_OFF) |=> !alarm_out && !alarm_state;
   endproperty
   a_off: assert property (p_off) else $error("alarm seen while off");
   property p_err;
      @(posedge core_clk) disable iff (!rstn)
      (monitored_error != pda_pkg::ERR_NONE && !disable_request
       && cfg_type != pda_pkg::PDA_TYPE_OFF && $stable(cfg_close_on_alarm))
      |=> alarm_state && alarm_out == cfg_close_on_alarm;
   endproperty
   a_err: assert property (p_err) else $error("input error gave no alarm");
   property p_stat;
      @(posedge core_clk) disable iff (!rstn) out_error_status == pda_pkg::ERR_NONE;
   endproperty
   a_stat: assert property (p_stat) else $error("own error status not none");
   property p_disp;
      @(posedge core_clk) disable iff (!rstn)
      display_attention |-> alarm_state && $past(cfg_display_en);
   endproperty
   a_disp: assert property (p_disp) else $error("attention flag without cause");
   property p_side;
      @(posedge core_clk) disable iff (!rstn)
      $rose(alarm_low) |-> $past(cfg_sides) != pda_pkg::PDA_SIDE_HIGH;
   endproperty
   a_side: assert property (p_side) else $error("low alarm on high only");
   property p_blk;
      @(posedge core_clk) disable iff (!rstn)
      $rose(alarm_high) |-> !$past(alarm_blocked) && $past(cfg_sides) != pda_pkg::PDA_SIDE_LOW;
   endproperty
   a_blk: assert property (p_blk) else $error("high alarm while blocked");
   property p_proc;
      @(posedge core_clk) disable iff (!rstn)
      (cfg_type == pda_pkg::PDA_TYPE_PROCESS && !disable_request && cfg_delay_s == '0
       && !alarm_blocked && cfg_sides != pda_pkg::PDA_SIDE_LOW
       && int'(monitored_value) > int'(cfg_high_limit)) |=> alarm_high;
   endproperty
   a_proc: assert property (p_proc) else $error("process high missed");
   property p_dev;
      @(posedge core_clk) disable iff (!rstn)
      (cfg_type == pda_pkg::PDA_TYPE_DEVIATION && !disable_request && cfg_delay_s == '0
       && !alarm_blocked && cfg_sides != pda_pkg::PDA_SIDE_HIGH
       && $stable(center_reference) && $stable(cfg_low_limit) && $stable(cfg_high_limit)
       && int'(monitored_value) < int'(center_reference) + int'(cfg_low_limit))
      |=> alarm_low;
   endproperty
   a_dev: assert property (p_dev) else $error("deviation low missed");
   property p_mute;
      @(posedge core_clk) disable iff (!rstn)
      (cfg_silence_en && mute_request && alarm_state && monitored_error == pda_pkg::ERR_NONE
       && !disable_request && cfg_type != pda_pkg::PDA_TYPE_OFF && $stable(cfg_close_on_alarm))
      |-> ##[1:2] alarm_out == !cfg_close_on_alarm;
   endproperty
   a_mute: assert property (p_mute) else $error("mute did not quiet output");
endmodule

bind pda_alarm pda_alarm_assertions i_chk (.*);

// ===== tb/pda_source_model.sv
/*
 * Measurement source and loop set point feeding the alarm block.
 * Assumes callers invoke drive just after a rising clock edge.
 */
`timescale 1ns/1ps
module pda_source_model (
   input wire logic core_clk,
   output logic signed [pda_pkg::VAL_W-1:0] monitored_value,
   output logic signed [pda_pkg::VAL_W-1:0] center_reference,
   output logic [pda_pkg::ERR_W-1:0] monitored_error
);
   initial begin
      monitored_value = '0;
      center_reference = '0;
      monitored_error = pda_pkg::ERR_NONE;
   end

   // Levels only: the source never handshakes, it just holds its value
   task automatic drive(input logic signed [pda_pkg::VAL_W-1:0] v, c,
                        input logic [pda_pkg::ERR_W-1:0] e);
      monitored_value = v;
      center_reference = c;
      monitored_error = e;
   endtask
endmodule

// ===== tb/pda_alarm_tb.sv
/*
 * Self-checking bench for the process/deviation alarm block.
 * Assumes the design package, the qualifier and the source model are compiled first.
 */
`timescale 1ns/1ps
module pda_alarm_tb;
   localparam int unsigned TCK = 10;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic signed [pda_pkg::VAL_W-1:0] monitored_value, center_reference;
   logic [pda_pkg::ERR_W-1:0] monitored_error, out_error_status;
   logic mute_request = 1'b0, acknowledge_request = 1'b0, disable_request = 1'b0;
   pda_pkg::pda_type_e cfg_type = pda_pkg::PDA_TYPE_PROCESS;
   pda_pkg::pda_side_e cfg_sides = pda_pkg::PDA_SIDE_BOTH;
   pda_pkg::pda_block_e cfg_blocking = pda_pkg::PDA_BLK_OFF;
   logic signed [pda_pkg::VAL_W-1:0] cfg_low_limit = -18'sh64, cfg_high_limit = 18'sh64;
   logic [pda_pkg::HYST_W-1:0] cfg_hysteresis = 14'h5;
   logic [pda_pkg::DELAY_W-1:0] cfg_delay_s = 14'h0;
   logic cfg_latching = 1'b0, cfg_silence_en = 1'b0, cfg_close_on_alarm = 1'b1;
   logic cfg_display_en = 1'b1, cfg_clear_param = 1'b0, cfg_silence_param = 1'b0;
   logic alarm_out, display_attention, alarm_state, alarm_high, alarm_low, alarm_blocked;
   int err_total = 0;
   int check_count = 0;

   always #20 core_clk = ~core_clk;

   pda_source_model i_src (.*);
   pda_alarm #(.TICK_CYCLES(TCK)) i_dut (.*);

   // ==========================================================
   // Tasks
   task step(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task chk(input string n, input logic [17:0] seen, input logic [17:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value %s expected %0h seen %0h", n, exp, seen);
      end
   endtask
   task co(input logic s, input logic o);
      chk("alarm_state", alarm_state, s);
      chk("alarm_out", alarm_out, o);
   endtask
   task put(input logic signed [17:0] v, c, input logic [3:0] e, input int n);
      i_src.drive(v, c, e);
      step(n);
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      #100us;
      err_total++;
      end_sim;
   end

   // ==========================================================
   // Tests
   initial begin
      step(10);
      rstn = 1'b1;
      step(2);
      put(18'sh65, 0, 0, 2); co(1, 1);
      chk("alarm_high", alarm_high, 1);
      chk("display_attention", display_attention, 1);
      put(18'sh60, 0, 0, 2); co(1, 1);
      put(18'sh5f, 0, 0, 2); co(0, 0);
      put(-18'sh65, 0, 0, 2); chk("alarm_low", alarm_low, 1);
      put(-18'sh60, 0, 0, 2); co(1, 1);
      put(-18'sh5f, 0, 0, 2); co(0, 0);
      cfg_sides = pda_pkg::PDA_SIDE_HIGH;
      put(-18'shc8, 0, 0, 2); co(0, 0);
      cfg_sides = pda_pkg::PDA_SIDE_LOW;
      put(18'shc8, 0, 0, 2); co(0, 0);
      cfg_sides = pda_pkg::PDA_SIDE_BOTH;
      cfg_close_on_alarm = 1'b0;
      cfg_display_en = 1'b0;
      step(2); co(1, 0);
      chk("display_attention", display_attention, 0);
      put(0, 0, 0, 2); co(0, 1);
      cfg_close_on_alarm = 1'b1;
      cfg_display_en = 1'b1;
      // Latching: a clear while the cause stands must be refused
      cfg_latching = 1'b1;
      for (int i = 0; i < 2; i++) begin
         put(18'shc8, 0, 0, 2);
         acknowledge_request = (i == 0);
         cfg_clear_param = (i == 1);
         step(2); co(1, 1);
         acknowledge_request = 1'b0;
         cfg_clear_param = 1'b0;
         put(0, 0, 0, 2); co(1, 1);
         acknowledge_request = (i == 0);
         cfg_clear_param = (i == 1);
         step(2); co(0, 0);
         acknowledge_request = 1'b0;
         cfg_clear_param = 1'b0;
      end
      cfg_latching = 1'b0;
      cfg_silence_en = 1'b1;
      for (int i = 0; i < 2; i++) begin
         put(18'shc8, 0, 0, 2);
         mute_request = (i == 0);
         cfg_silence_param = (i == 1);
         step(3); co(1, 0);
         mute_request = 1'b0;
         cfg_silence_param = 1'b0;
         step(2); co(1, 0);
         put(0, 0, 0, 2); co(0, 0);
         put(18'shc8, 0, 0, 2); co(1, 1);
         put(0, 0, 0, 2);
      end
      cfg_silence_en = 1'b0;
      put(18'shc8, 0, 0, 2);
      mute_request = 1'b1;
      step(3); co(1, 1);
      mute_request = 1'b0;
      disable_request = 1'b1;
      step(2); co(0, 0);
      disable_request = 1'b0;
      cfg_type = pda_pkg::PDA_TYPE_OFF;
      step(2); co(0, 0);
      cfg_type = pda_pkg::PDA_TYPE_PROCESS;
      put(0, 0, 4'h3, 2); co(1, 1);
      chk("out_error_status", out_error_status, pda_pkg::ERR_NONE);
      put(0, 0, 0, 2); co(0, 0);
      // Deviation window around a moving center
      cfg_type = pda_pkg::PDA_TYPE_DEVIATION;
      cfg_high_limit = 18'sh32;
      cfg_low_limit = -18'sh32;
      put(18'sh433, 18'sh400, 0, 2); chk("alarm_high", alarm_high, 1);
      put(18'sh433, 18'sh440, 0, 2); co(0, 0);
      put(18'sh40d, 18'sh440, 0, 2); chk("alarm_low", alarm_low, 1);
      put(18'sh412, 18'sh440, 0, 2); co(1, 1);
      put(18'sh413, 18'sh440, 0, 2); co(0, 0);
      cfg_low_limit = 18'sh14;
      put(18'sh450, 18'sh440, 0, 2); chk("alarm_low", alarm_low, 1);
      cfg_low_limit = -18'sh32;
      // Set-point blocking re-arms when the center moves
      cfg_blocking = pda_pkg::PDA_BLK_SETPOINT;
      put(18'sh440, 18'sh440, 0, 3);
      put(18'sh440, 18'sh500, 0, 3); co(0, 0);
      chk("alarm_blocked", alarm_blocked, 1);
      put(18'sh500, 18'sh500, 0, 3); chk("alarm_blocked", alarm_blocked, 0);
      cfg_blocking = pda_pkg::PDA_BLK_OFF;
      cfg_type = pda_pkg::PDA_TYPE_PROCESS;
      cfg_high_limit = 18'sh64;
      cfg_low_limit = -18'sh64;
      // Delay: an early return must restart the count
      cfg_delay_s = 14'h2;
      put(18'shc8, 0, 0, 15); co(0, 0);
      put(0, 0, 0, 2);
      put(18'shc8, 0, 0, 18); co(0, 0);
      step(6); co(1, 1);
      put(0, 0, 0, 2);
      cfg_delay_s = 14'h0;
      // Startup blocking arms at reset
      cfg_blocking = pda_pkg::PDA_BLK_STARTUP;
      put(18'shc8, 0, 0, 1);
      rstn = 1'b0;
      step(10);
      rstn = 1'b1;
      step(4); co(0, 0);
      chk("alarm_blocked", alarm_blocked, 1);
      put(0, 0, 0, 2); chk("alarm_blocked", alarm_blocked, 0);
      put(18'shc8, 0, 0, 2); co(1, 1);
      // Both: a limit or center change re-arms deviation blocking
      cfg_blocking = pda_pkg::PDA_BLK_BOTH;
      cfg_type = pda_pkg::PDA_TYPE_DEVIATION;
      cfg_high_limit = 18'sh32;
      cfg_low_limit = -18'sh32;
      put(0, 0, 0, 3); co(0, 0);
      chk("alarm_blocked", alarm_blocked, 0);
      put(0, 18'sh100, 0, 2); co(0, 0);
      chk("alarm_blocked", alarm_blocked, 1);
      end_sim;
   end
endmodule
